/* bench/pcs_board_pins.sv */
// Board strap pins model
`timescale 1ns/10ps
`default_nettype none
`include "pcs_cfg.svh"
module pcs_board_pins (
  // Wanted settings
  input wire pcs_pkg::pcs_strap_s want,
  input wire logic [4:0] media,
  input wire logic allow_bad,
  // Pins into the decoder
  output var pcs_pkg::pcs_strap_s strap_in,
  output var logic port_select_mode,
  output var logic [`PCS_NPORTS-1:0] per_port_media_select
);
  import pcs_pkg::*;
  always_comb begin
    strap_in = want;
    // Fiber only at 100 Mbps unless told to misbehave
    if (!want.an_enable && (want.iface || |media[3:0]) && !allow_bad) strap_in.speed = 1'b1;
    {port_select_mode, per_port_media_select} = media;
  end
endmodule
`default_nettype wire

/* bench/pcs_strap_props.sv */
// Assertion checker for the strap decoder
`timescale 1ns/10ps
`default_nettype none
`include "pcs_cfg.svh"
module pcs_strap_props (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Observed ports
  input wire pcs_pkg::pcs_strap_s strap_in,
  input wire logic port_select_mode,
  input wire pcs_pkg::pcs_port_cfg_s [`PCS_NPORTS-1:0] port_cfg_ff,
  input wire pcs_pkg::pcs_strap_s strap_latched_ff,
  input wire logic cfg_valid_ff,
  input wire logic fiber_10m_err_ff
);
  import pcs_pkg::*;
  pcs_port_cfg_s p;
  pcs_strap_s s;
  logic was_ff, ok, off, h10, h100, bad;
  assign p = port_cfg_ff[0];
  assign s = strap_latched_ff;
  assign ok = was_ff && cfg_valid_ff;
  assign off = !s.an_enable;
  assign h100 = !s.iface || s.link_test;
  assign h10 = s.iface || !s.link_test;
  always_comb begin
    bad = 1'b0;
    for (int i = 0; i < `PCS_NPORTS; i++) bad |= port_cfg_ff[i].fiber & !port_cfg_ff[i].speed_100;
  end
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) was_ff <= 1'b0;
    else was_ff <= cfg_valid_ff;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  a_capture_stable:
    assert property ($rose(cfg_valid_ff) |-> $past(strap_in, 1) == s && $past(strap_in, 2) == s
      && $past(strap_in, 3) == s && $past(strap_in, 4) == s) else $error("unsettled capture");
  a_run_hold:
    assert property (ok |-> $stable(s)) else $error("straps relatched in run");
  a_link_test:
    assert property (ok && off |-> p.link_test_off == s.link_test && p.mii_19_8 == s.link_test)
      else $error("link test bit wrong");
  a_speed_bit:
    assert property (ok && off |-> p.speed_100 == s.speed && p.mii_0_13 == s.speed)
      else $error("speed bit wrong");
  a_strap_media:
    assert property (ok && off && !$past(port_select_mode) |-> p.fiber == s.iface
      && p.mii_19_2 == s.iface) else $error("media choice wrong");
  a_scram_bypass:
    assert property (ok |-> p.scram_bypass == p.fiber
      && port_cfg_ff[3].scram_bypass == port_cfg_ff[3].fiber) else $error("scrambler wrong");
  a_adv_table:
    assert property (ok && !off |-> p.adv == {h100 & s.full_duplex_strap, h100,
      h10 & s.full_duplex_strap, h10} && port_cfg_ff[3].adv == p.adv && !p.fiber)
      else $error("advertisement wrong");
  a_fiber_flag:
    assert property (ok && $past(ok) |-> fiber_10m_err_ff == bad)
      else $error("fiber speed flag wrong");
endmodule
bind pcs_strap_decode pcs_strap_props u_props (.ref_clk(ref_clk), .rstn(rstn),
  .strap_in(strap_in), .port_select_mode(port_select_mode), .port_cfg_ff(port_cfg_ff),
  .strap_latched_ff(strap_latched_ff), .cfg_valid_ff(cfg_valid_ff),
  .fiber_10m_err_ff(fiber_10m_err_ff));
`default_nettype wire

/* bench/test_pcs_strap_decode.sv */
// Testbench for the strap decoder
`timescale 1ns/10ps
`default_nettype none
`include "pcs_cfg.svh"
module test_pcs_strap_decode;
  import pcs_pkg::*;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic strap_reload = 1'b0;
  logic allow_bad = 1'b0;
  logic [4:0] media = 5'h00;
  pcs_strap_s want = '0;
  pcs_strap_s strap_in, strap_latched_ff;
  logic port_select_mode, cfg_valid_ff, fiber_10m_err_ff;
  logic [`PCS_NPORTS-1:0] per_port_media_select;
  pcs_port_cfg_s [`PCS_NPORTS-1:0] port_cfg_ff;
  int errors = 0;
  int checked = 0;
  always #50 ref_clk = !ref_clk;
  pcs_board_pins board (.want(want), .media(media), .allow_bad(allow_bad), .strap_in(strap_in),
    .port_select_mode(port_select_mode), .per_port_media_select(per_port_media_select));
  pcs_strap_decode DUT (.ref_clk(ref_clk), .rstn(rstn), .strap_in(strap_in),
    .port_select_mode(port_select_mode), .per_port_media_select(per_port_media_select),
    .strap_reload(strap_reload), .port_cfg_ff(port_cfg_ff), .strap_latched_ff(strap_latched_ff),
    .cfg_valid_ff(cfg_valid_ff), .fiber_10m_err_ff(fiber_10m_err_ff));
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input logic [12:0] seen, input logic [12:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic pcs_port_cfg_s expect_cfg(pcs_strap_s s, logic [4:0] m, int i);
    pcs_port_cfg_s e;
    logic h10, h100;
    e = '0;
    h100 = !s.iface || s.link_test;
    h10 = s.iface || !s.link_test;
    e.full_duplex = s.full_duplex_strap;
    if (s.an_enable) begin
      e.adv = {h100 & s.full_duplex_strap, h100, h10 & s.full_duplex_strap, h10};
      e.speed_100 = h100;
    end else begin
      e.speed_100 = s.speed;
      e.link_test_off = s.link_test;
      e.fiber = m[4] ? m[i] : s.iface;
    end
    e.scram_bypass = e.fiber;
    e.mii_0_13 = e.speed_100;
    e.mii_19_8 = e.link_test_off;
    e.mii_19_2 = e.fiber;
    return e;
  endfunction
  // Reload the straps and wait for the new capture to reach every output
  task automatic load(input pcs_strap_s w, input logic [4:0] m);
    int n;
    @(negedge ref_clk);
    want = w;
    media = m;
    strap_reload = 1'b1;
    @(negedge ref_clk);
    strap_reload = 1'b0;
    @(negedge ref_clk);
    n = 0;
    while (cfg_valid_ff !== 1'b1 && n < 20) begin
      @(negedge ref_clk);
      n++;
    end
    if (n == 20) begin
      errors++;
      report_and_stop();
    end
    repeat (2) @(negedge ref_clk);
    check(13'(strap_latched_ff), 13'(strap_in));
    for (int i = 0; i < `PCS_NPORTS; i++) begin
      check(port_cfg_ff[i], expect_cfg(strap_in, media, i));
    end
  endtask
  task automatic test_an_off();
    for (int k = 0; k < 8; k++) load({1'b0, 3'(k), k[0]}, 5'h00);
    $display("negotiation off done");
  endtask
  task automatic test_an_on();
    for (int k = 0; k < 8; k++) load({2'h2, 3'(k)}, 5'h00);
    $display("negotiation on done");
  endtask
  task automatic test_refuse();
    pcs_strap_s old;
    old = strap_in;
    want = ~old;
    repeat (8) @(negedge ref_clk);
    check(13'(strap_latched_ff), 13'(old));
    want = old;
    $display("run hold done");
  endtask
  task automatic test_per_port();
    allow_bad = 1'b1;
    load(5'h00, 5'h15);
    check(13'(fiber_10m_err_ff), 13'h1);
    allow_bad = 1'b0;
    load(5'h00, 5'h1a);
    check(13'(fiber_10m_err_ff), 13'h0);
    $display("per port media done");
  endtask
  task automatic test_reset();
    rstn = 1'b0;
    @(negedge ref_clk);
    check(13'(cfg_valid_ff), 13'h0);
    check(port_cfg_ff[0], 13'h0);
    rstn = 1'b1;
    load(5'h0e, 5'h00);
    $display("mid-run reset done");
  endtask
  initial begin
    repeat (3) @(negedge ref_clk);
    rstn = 1'b1;
    test_an_off();
    test_an_on();
    test_refuse();
    test_per_port();
    test_reset();
    report_and_stop();
  end
endmodule
`default_nettype wire

/* rtl/pcs_adv_decode.sv */
// Speed advertisement decode from the latched straps
`timescale 1ns/10ps
`default_nettype none
`include "pcs_cfg.svh"

module pcs_adv_decode (
  // Latched straps
  input wire pcs_pkg::pcs_strap_s straps,
  // Advertised abilities, zero when negotiation is off
  output logic [`PCS_ADV_W-1:0] adv
);
  import pcs_pkg::*;

  function automatic pcs_adv_t adv_of(input logic [1:0] mode, input logic fd);
    pcs_adv_t a;
    a = `PCS_ADV_NONE;
    case (mode)
      `PCS_ADV_MODE_100: begin
        a[`PCS_ADV_100HD] = 1'b1;
      end
      `PCS_ADV_MODE_10: begin
        a[`PCS_ADV_10HD] = 1'b1;
      end
      default: begin
        a[`PCS_ADV_10HD] = 1'b1;
        a[`PCS_ADV_100HD] = 1'b1;
      end
    endcase
    // Full duplex abilities only where the half duplex one is offered
    a[`PCS_ADV_10FD] = fd & a[`PCS_ADV_10HD];
    a[`PCS_ADV_100FD] = fd & a[`PCS_ADV_100HD];
    return a;
  endfunction

  always_comb begin
    if (straps.an_enable) begin
      adv = adv_of({straps.iface, straps.link_test}, straps.full_duplex_strap);
    end else begin
      adv = `PCS_ADV_NONE;
    end
  end

endmodule
`default_nettype wire

/* rtl/pcs_cfg.svh */
// Constants for the configuration strap decoder
`ifndef PCS_CFG_SVH
`define PCS_CFG_SVH

`define PCS_NPORTS 4
`define PCS_ADV_W 4
`define PCS_ADV_10HD 0
`define PCS_ADV_10FD 1
`define PCS_ADV_100HD 2
`define PCS_ADV_100FD 3
`define PCS_ADV_NONE 4'h0
`define PCS_ADV_MODE_ALL 2'h0
`define PCS_ADV_MODE_100 2'h1
`define PCS_ADV_MODE_10 2'h2
`define PCS_ADV_MODE_ALT 2'h3
`define PCS_CNT_W 4
`define PCS_CNT_ZERO 4'h0
`define PCS_CNT_ONE 4'h1
`define PCS_CLK_NS 100
`define PCS_SETTLE_NS 300
`define PCS_SETTLE_CYC ((`PCS_SETTLE_NS + `PCS_CLK_NS - 1) / `PCS_CLK_NS)
`define PCS_SYNC_W 2
`define PCS_SYNC_RST 2'h0

`endif

/* rtl/pcs_pkg.sv */
// Types shared by the configuration strap decoder
`include "pcs_cfg.svh"

package pcs_pkg;

  typedef enum logic [1:0] {
    PCS_ST_WAIT = 2'b00,
    PCS_ST_SETTLE = 2'b01,
    PCS_ST_RUN = 2'b10
  } pcs_state_e;

  typedef logic [`PCS_ADV_W-1:0] pcs_adv_t;

  typedef struct packed {
    logic an_enable;
    logic speed;
    logic link_test;
    logic iface;
    logic full_duplex_strap;
  } pcs_strap_s;

  typedef struct packed {
    logic speed_100;
    logic link_test_off;
    logic fiber;
    logic scram_bypass;
    logic full_duplex;
    pcs_adv_t adv;
    logic mii_0_13;
    logic mii_19_8;
    logic mii_19_2;
  } pcs_port_cfg_s;

endpackage

/* rtl/pcs_strap_decode.sv */
// Chip-wide configuration strap capture and per-port decode
`timescale 1ns/10ps
`default_nettype none
`include "pcs_cfg.svh"

// Functional notes
// - With negotiation on, advertised speeds on all ports come from link-test, interface and duplex straps.
// - With negotiation off and link-test strap high, the 10 Mbps link test is off and bit 19.8 reads one.
// - With negotiation off and link-test strap low, the 10 Mbps link test stays on and bit 19.8 reads zero.
// - With negotiation on, the interface strap joins the link-test strap to pick advertised speeds.
// - With negotiation off and port_select_mode low, the interface strap chooses twisted pair or fiber media.
// - Selecting fiber bypasses the transmit scrambler and sets bit 19.2; fiber at 10 Mbps also raises the error flag.
// - With negotiation off, speed strap high gives 100 Mbps and bit 0.13 one, low gives 10 Mbps and zero.
// - With the interface strap low and port_select_mode low, twisted pair is used and bit 19.2 reads zero.
module pcs_strap_decode (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Chip-wide straps from the board
  input wire pcs_pkg::pcs_strap_s strap_in,
  // Per-port media choice without negotiation: port_select_mode high enables it, per_port_media_select high picks fiber
  input wire logic port_select_mode,
  input wire logic [`PCS_NPORTS-1:0] per_port_media_select,
  // Request to capture the straps again
  input wire logic strap_reload,
  // Decoded configuration and status
  output var pcs_pkg::pcs_port_cfg_s [`PCS_NPORTS-1:0] port_cfg_ff,
  output var pcs_pkg::pcs_strap_s strap_latched_ff,
  output var logic cfg_valid_ff,
  output var logic fiber_10m_err_ff
);
  import pcs_pkg::*;

  localparam logic [`PCS_CNT_W-1:0] SETTLE_CNT = `PCS_CNT_W'(`PCS_SETTLE_CYC);

  // Media choice of one port; forced media only without negotiation
  function automatic logic fiber_of(input logic an, input logic mode, input logic sel,
                                    input logic iface);
    logic f;
    f = 1'b0;
    if (!an) begin
      f = mode ? sel : iface;
    end
    return f;
  endfunction

  // Reset release through two flops
  logic [`PCS_SYNC_W-1:0] rst_sync_ff;
  logic rst_n_sync;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rst_sync_ff <= `PCS_SYNC_RST;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end

  assign rst_n_sync = rst_sync_ff[1];

  // Strap capture: straps must hold steady for the settle time
  pcs_state_e state_ff;
  pcs_state_e nxt_state;
  logic [`PCS_CNT_W-1:0] cnt_ff;
  logic [`PCS_CNT_W-1:0] nxt_cnt;
  pcs_strap_s sample_ff;
  pcs_strap_s nxt_sample;
  pcs_strap_s nxt_strap_latched;
  logic nxt_cfg_valid;

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_sample = sample_ff;
    nxt_strap_latched = strap_latched_ff;
    case (state_ff)
      PCS_ST_WAIT: begin
        nxt_sample = strap_in;
        nxt_cnt = `PCS_CNT_ZERO;
        nxt_state = PCS_ST_SETTLE;
      end
      PCS_ST_SETTLE: begin
        nxt_sample = strap_in;
        if (strap_in != sample_ff) begin
          nxt_cnt = `PCS_CNT_ZERO;
        end else if (cnt_ff == SETTLE_CNT) begin
          nxt_strap_latched = sample_ff;
          nxt_state = PCS_ST_RUN;
        end else begin
          nxt_cnt = `PCS_CNT_W'(cnt_ff + `PCS_CNT_ONE);
        end
      end
      PCS_ST_RUN: begin
        if (strap_reload) begin
          nxt_cnt = `PCS_CNT_ZERO;
          nxt_sample = strap_in;
          nxt_state = PCS_ST_SETTLE;
        end
      end
      default: begin
        nxt_state = PCS_ST_WAIT;
        nxt_cnt = `PCS_CNT_ZERO;
      end
    endcase
    nxt_cfg_valid = (nxt_state == PCS_ST_RUN);
  end

  always_ff @(posedge ref_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      state_ff <= PCS_ST_WAIT;
      cnt_ff <= `PCS_CNT_ZERO;
      sample_ff <= '0;
      strap_latched_ff <= '0;
      cfg_valid_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      sample_ff <= nxt_sample;
      strap_latched_ff <= nxt_strap_latched;
      cfg_valid_ff <= nxt_cfg_valid;
    end
  end

  // Advertisement shared by every port
  pcs_adv_t adv_w;

  pcs_adv_decode u_adv (
    .straps(strap_latched_ff),
    .adv(adv_w)
  );

  // Per-port decode
  logic [`PCS_NPORTS-1:0] fiber_slow;

  for (genvar p = 0; p < `PCS_NPORTS; p++) begin : g_port
    pcs_port_cfg_s nxt_cfg;

    always_comb begin
      nxt_cfg = '0;
      nxt_cfg.full_duplex = strap_latched_ff.full_duplex_strap;
      if (strap_latched_ff.an_enable) begin
        nxt_cfg.adv = adv_w;
        nxt_cfg.speed_100 = adv_w[`PCS_ADV_100HD];
        nxt_cfg.link_test_off = 1'b0;
      end else begin
        nxt_cfg.adv = `PCS_ADV_NONE;
        nxt_cfg.speed_100 = strap_latched_ff.speed;
        nxt_cfg.link_test_off = strap_latched_ff.link_test;
      end
      nxt_cfg.fiber = fiber_of(strap_latched_ff.an_enable, port_select_mode,
                               per_port_media_select[p], strap_latched_ff.iface);
      nxt_cfg.scram_bypass = nxt_cfg.fiber;
      nxt_cfg.mii_0_13 = nxt_cfg.speed_100;
      nxt_cfg.mii_19_8 = nxt_cfg.link_test_off;
      nxt_cfg.mii_19_2 = nxt_cfg.fiber;
    end

    assign fiber_slow[p] = nxt_cfg.fiber & ~nxt_cfg.speed_100;

    always_ff @(posedge ref_clk or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
        port_cfg_ff[p] <= '0;
      end else begin
        port_cfg_ff[p] <= nxt_cfg;
      end
    end
  end

  // Fiber at 10 Mbps is a board error; flagged only on a valid capture
  logic nxt_fiber_10m_err;

  always_comb begin
    nxt_fiber_10m_err = (state_ff == PCS_ST_RUN) & (|fiber_slow);
  end

  always_ff @(posedge ref_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      fiber_10m_err_ff <= 1'b0;
    end else begin
      fiber_10m_err_ff <= nxt_fiber_10m_err;
    end
  end

endmodule
`default_nettype wire
